// file: logic/rxeb_elastic.sv
`timescale 1ns/1ps
// Summary of operation
// - thirty-two entries of 64 data plus 8 control
// - empty buffer outputs local fault words
// - above half, drop incoming rate match sequences
// - below half, insert extra rate match sequences
// - overflow discards words that cannot be stored
// - half start absorbs fast stream without drops
// - half start absorbs slow stream without faults
module rxeb_elastic #(
    parameter int DEPTH = rxeb_pkg::DEPTH
) (
    input  wire logic                        rx_link_clk,
    input  wire logic                        rx_link_srst,
    input  wire logic [rxeb_pkg::DATA_W-1:0] rx_in_data,
    input  wire logic [rxeb_pkg::CTRL_W-1:0] rx_in_ctrl,
    input  wire logic                        rx_in_valid,
    input  wire logic                        clk,
    input  wire logic                        srst,
    output logic [rxeb_pkg::DATA_W-1:0]      rx_out_data,
    output logic [rxeb_pkg::CTRL_W-1:0]      rx_out_ctrl,
    output logic                             rx_out_fault,
    output logic                             rx_out_inserted,
    output logic                             rx_drop_pulse,
    output logic                             rx_delete_pulse
);
    import rxeb_pkg::*;

    // ------------------------------------------------------------------
    // link side signals
    // ------------------------------------------------------------------
    logic [PTR_W-1:0]  wr_fill;        // fill seen at link side
    logic              wr_ready;       // fifo can take a word
    logic              drop_q;         // overflow pulse, link domain
    logic              del_q;          // deletion pulse, link domain
    logic              drop_tgl_q;     // drop event toggle
    logic              del_tgl_q;      // delete event toggle

    // ------------------------------------------------------------------
    // core side signals
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] rd_word;        // head of fifo
    logic              rd_valid;       // fifo not empty
    logic [PTR_W-1:0]  rd_fill;        // fill seen at core side
    logic              pop_w;          // take head word this cycle
    rxeb_rd_state_type state_q;        // read side state
    rxeb_rd_state_type state_d;
    logic [DATA_W-1:0] out_data_q;     // registered output data
    logic [CTRL_W-1:0] out_ctrl_q;     // registered output control
    logic              fault_q;        // registered fault flag
    logic              ins_q;          // registered insert flag
    logic [2:0]        drop_sync_q;    // drop toggle sync plus edge
    logic [2:0]        del_sync_q;     // delete toggle sync plus edge
    logic              drop_p_q;       // drop pulse, core domain
    logic              del_p_q;        // delete pulse, core domain

    // rate match word test, used on both sides
    function automatic logic is_rm(input logic [DATA_W-1:0] d, input logic [CTRL_W-1:0] c);
        return (d == RM_DATA) && (c == RM_CTRL);
    endfunction

    // ------------------------------------------------------------------
    // write side decisions
    // ------------------------------------------------------------------
    wire in_rm    = is_rm(rx_in_data, rx_in_ctrl);
    wire over_h   = wr_fill > PTR_W'(HALF);
    wire del_now  = rx_in_valid && in_rm && over_h;
    wire push_w   = rx_in_valid && !del_now;
    wire drop_now = push_w && !wr_ready;

    // ------------------------------------------------------------------
    // storage, dual clock
    // ------------------------------------------------------------------
    rxeb_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH),
        .AW    (PTR_W-1)
    ) u_fifo (
        .wr_clk   (rx_link_clk),
        .wr_srst  (rx_link_srst),
        .wr_data  ({rx_in_ctrl, rx_in_data}),
        .wr_valid (push_w),
        .wr_ready (wr_ready),
        .wr_fill  (wr_fill),
        .rd_clk   (clk),
        .rd_srst  (srst),
        .rd_data  (rd_word),
        .rd_valid (rd_valid),
        .rd_ready (pop_w),
        .rd_fill  (rd_fill)
    );

    // ------------------------------------------------------------------
    // link domain event pulses and toggles
    // ------------------------------------------------------------------
    // events cross as toggles; two events between two core clock edges cancel out
    always_ff @(posedge rx_link_clk) begin
        if (rx_link_srst) begin
            drop_q     <= 1'b0;
            del_q      <= 1'b0;
            drop_tgl_q <= 1'b0;
            del_tgl_q  <= 1'b0;
        end else begin
            drop_q     <= drop_now;
            del_q      <= del_now;
            drop_tgl_q <= drop_tgl_q ^ drop_q;
            del_tgl_q  <= del_tgl_q ^ del_q;
        end
    end

    // ------------------------------------------------------------------
    // read side control
    // ------------------------------------------------------------------
    wire head_rm   = is_rm(rd_word[DATA_W-1:0], rd_word[WORD_W-1:DATA_W]);
    wire under_h   = rd_fill < PTR_W'(HALF);
    wire reached_h = rd_fill >= PTR_W'(HALF);
    // hold a rate match word at the head while under half: repeat it
    wire insert_w  = (state_q == RXEB_RUN) && rd_valid && head_rm && under_h;
    assign pop_w   = (state_q == RXEB_RUN) && rd_valid && !insert_w;
    wire emit_lf   = (state_q != RXEB_RUN) || !rd_valid;

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            RXEB_FILL: begin
                if (reached_h) begin
                    state_d = RXEB_RUN;     // start from half
                end
            end
            RXEB_RUN: begin
                if (!rd_valid) begin
                    state_d = RXEB_FAULT;   // ran dry
                end
            end
            RXEB_FAULT: begin
                if (reached_h) begin
                    state_d = RXEB_RUN;     // refill to half first
                end
            end
            default: begin
                state_d = RXEB_FILL;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= RXEB_FILL;
        end else begin
            state_q <= state_d;
        end
    end

    // output word register
    always_ff @(posedge clk) begin
        if (srst) begin
            out_data_q <= LF_DATA;
            out_ctrl_q <= LF_CTRL;
            fault_q    <= 1'b1;
            ins_q      <= 1'b0;
        end else if (emit_lf) begin
            out_data_q <= LF_DATA;
            out_ctrl_q <= LF_CTRL;
            fault_q    <= 1'b1;
            ins_q      <= 1'b0;
        end else begin
            out_data_q <= rd_word[DATA_W-1:0];
            out_ctrl_q <= rd_word[WORD_W-1:DATA_W];
            fault_q    <= 1'b0;
            ins_q      <= insert_w;
        end
    end

    // ------------------------------------------------------------------
    // event crossing into core domain
    // ------------------------------------------------------------------
    // stage 0 feeds only stage 1; edge taken between stages 1 and 2
    always_ff @(posedge clk) begin
        if (srst) begin
            drop_sync_q <= '0;
            del_sync_q  <= '0;
            drop_p_q    <= 1'b0;
            del_p_q     <= 1'b0;
        end else begin
            drop_sync_q <= {drop_sync_q[1:0], drop_tgl_q};
            del_sync_q  <= {del_sync_q[1:0], del_tgl_q};
            drop_p_q    <= drop_sync_q[2] ^ drop_sync_q[1];
            del_p_q     <= del_sync_q[2] ^ del_sync_q[1];
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rx_out_data     = out_data_q;
    assign rx_out_ctrl     = out_ctrl_q;
    assign rx_out_fault    = fault_q;
    assign rx_out_inserted = ins_q;
    assign rx_drop_pulse   = drop_p_q;
    assign rx_delete_pulse = del_p_q;
endmodule

// file: logic/rxeb_pkg.sv
package rxeb_pkg;
    // ------------------------------------------------------------------
    // stored word layout
    // ------------------------------------------------------------------
    localparam int DATA_W  = 64;             // data bits per word
    localparam int CTRL_W  = 8;              // control bits per word
    localparam int WORD_W  = DATA_W + CTRL_W; // stored word width
    localparam int DEPTH   = 32;             // buffer entries
    localparam int PTR_W   = 6;              // pointer width incl. wrap bit
    localparam int HALF    = DEPTH / 2;      // target fill
    localparam int SYNC_STAGES = 2;          // pointer synchroniser stages

    // ------------------------------------------------------------------
    // code words
    // ------------------------------------------------------------------
    // local fault ordered set: control on lanes 0 and 4, seq 0x9C, fault 0x01
    localparam logic [DATA_W-1:0] LF_DATA = 64'h0100009C_0100009C;
    localparam logic [CTRL_W-1:0] LF_CTRL = 8'h11;
    // rate match sequence: all idle characters
    localparam logic [DATA_W-1:0] RM_DATA = 64'h07070707_07070707;
    localparam logic [CTRL_W-1:0] RM_CTRL = 8'hFF;

    // ------------------------------------------------------------------
    // read side states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RXEB_FILL  = 2'b00,  // waiting to reach half before first read
        RXEB_RUN   = 2'b01,  // normal delivery
        RXEB_FAULT = 2'b10   // emptied, emitting local fault
    } rxeb_rd_state_type;
endpackage

// file: logic/rxeb_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// dual clock fifo with gray pointers
// ----------------------------------------------------------------------
module rxeb_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_srst,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    output logic [AW:0]           wr_fill,
    input  wire logic             rd_clk,
    input  wire logic             rd_srst,
    output logic [WIDTH-1:0]      rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [AW:0]           rd_fill
);
    import rxeb_pkg::*;

    logic [WIDTH-1:0] mem_q [DEPTH];   // storage flip-flops
    logic [AW:0]      wbin_q;          // write pointer binary
    logic [AW:0]      wgray_q;         // write pointer gray
    logic [AW:0]      rbin_q;          // read pointer binary
    logic [AW:0]      rgray_q;         // read pointer gray
    logic [AW:0]      rg_s1_q;         // read gray sync stage 1
    logic [AW:0]      rg_s2_q;         // read gray sync stage 2
    logic [AW:0]      wg_s1_q;         // write gray sync stage 1
    logic [AW:0]      wg_s2_q;         // write gray sync stage 2

    // gray to binary conversion, used on both sides
    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = '0;
        for (int i = AW; i >= 0; i--) begin
            b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction

    wire [AW:0] rbin_w   = g2b(rg_s2_q);             // read ptr in write domain
    wire [AW:0] wbin_r   = g2b(wg_s2_q);             // write ptr in read domain
    wire [AW:0] wfill_w  = wbin_q - rbin_w;          // fill seen by writer
    wire [AW:0] rfill_w  = wbin_r - rbin_q;          // fill seen by reader
    wire        full_w   = (wfill_w == (AW+1)'(DEPTH)); // honest full
    wire        empty_w  = (rfill_w == '0);          // honest empty
    wire        push_w   = wr_valid && !full_w;
    wire        pop_w    = rd_ready && !empty_w;
    wire [AW:0] wbin_n   = wbin_q + (AW+1)'(1);
    wire [AW:0] rbin_n   = rbin_q + (AW+1)'(1);

    assign wr_ready = !full_w;
    assign wr_fill  = wfill_w;
    assign rd_valid = !empty_w;
    assign rd_fill  = rfill_w;
    assign rd_data  = mem_q[rbin_q[AW-1:0]];

    // write side: store only, pointers advance below
    always_ff @(posedge wr_clk) begin
        if (push_w) begin
            mem_q[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    // write pointers and read pointer synchroniser
    always_ff @(posedge wr_clk) begin
        if (wr_srst) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
            if (push_w) begin
                wbin_q  <= wbin_n;
                wgray_q <= wbin_n ^ (wbin_n >> 1);
            end
        end
    end

    // read pointers and write pointer synchroniser
    always_ff @(posedge rd_clk) begin
        if (rd_srst) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
            if (pop_w) begin
                rbin_q  <= rbin_n;
                rgray_q <= rbin_n ^ (rbin_n >> 1);
            end
        end
    end
endmodule

// file: dv/rxeb_elastic_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// output side checks
// ----------------------------------------
module rxeb_elastic_chk #(
    parameter int DEPTH = rxeb_pkg::DEPTH
) (
    input wire logic                        clk,
    input wire logic                        srst,
    input wire logic [rxeb_pkg::DATA_W-1:0] rx_out_data,
    input wire logic [rxeb_pkg::CTRL_W-1:0] rx_out_ctrl,
    input wire logic                        rx_out_fault,
    input wire logic                        rx_out_inserted,
    input wire logic                        rx_drop_pulse,
    input wire logic                        rx_delete_pulse
);
    import rxeb_pkg::*;
    rst_fault_a: assert property (@(posedge clk) srst |=> rx_out_fault)
        else $error("no fault word after reset");
    rst_quiet_a: assert property (@(posedge clk) srst |=> !rx_drop_pulse && !rx_delete_pulse)
        else $error("event pulse after reset");
    fault_word_a: assert property (@(posedge clk) disable iff (srst)
        rx_out_fault |-> rx_out_data == LF_DATA && rx_out_ctrl == LF_CTRL)
        else $error("fault flag without fault word");
    ins_word_a: assert property (@(posedge clk) disable iff (srst)
        rx_out_inserted |-> rx_out_data == RM_DATA && rx_out_ctrl == RM_CTRL && !rx_out_fault)
        else $error("inserted word is not a rate match word");
    drop_once_a: assert property (@(posedge clk) disable iff (srst)
        rx_drop_pulse |=> !rx_drop_pulse) else $error("drop pulse too long");
    del_once_a: assert property (@(posedge clk) disable iff (srst)
        rx_delete_pulse |=> !rx_delete_pulse) else $error("delete pulse too long");
    fault_exit_a: assert property (@(posedge clk) disable iff (srst)
        $fell(rx_out_fault) |-> !rx_out_inserted) else $error("insert right after refill");
    ins_hold_a: assert property (@(posedge clk) disable iff (srst)
        rx_out_inserted |=> !rx_out_fault) else $error("fault while rate match held");
endmodule
bind rxeb_elastic rxeb_elastic_chk #(.DEPTH(DEPTH)) u_chk (.clk(clk), .srst(srst),
    .rx_out_data(rx_out_data), .rx_out_ctrl(rx_out_ctrl), .rx_out_fault(rx_out_fault),
    .rx_out_inserted(rx_out_inserted), .rx_drop_pulse(rx_drop_pulse),
    .rx_delete_pulse(rx_delete_pulse));

// file: dv/rxeb_link_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// decoder side word source
// ----------------------------------------
module rxeb_link_src (
    input wire logic                   rx_link_clk,
    input wire logic                   rx_link_srst,
    output logic [rxeb_pkg::DATA_W-1:0] rx_in_data,
    output logic [rxeb_pkg::CTRL_W-1:0] rx_in_ctrl,
    output logic                        rx_in_valid
);
    import rxeb_pkg::*;
    logic [WORD_W-1:0] q_words[$]; // words waiting to go
    task automatic push(input logic [WORD_W-1:0] w);
        q_words.push_back(w);
    endtask
    initial begin
        rx_in_valid = 1'b0;
        {rx_in_ctrl, rx_in_data} = '0;
    end
    // one word per link edge, no back-pressure
    always @(posedge rx_link_clk) begin
        if (!rx_link_srst && q_words.size() > 0) begin
            {rx_in_ctrl, rx_in_data} <= q_words.pop_front();
            rx_in_valid <= 1'b1;
        end else begin
            // idle: stale lanes flip so they are never reused
            {rx_in_ctrl, rx_in_data} <= ~{rx_in_ctrl, rx_in_data};
            rx_in_valid <= 1'b0;
        end
    end
endmodule

// file: dv/rxeb_elastic_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// elastic buffer bench
// ----------------------------------------
module rxeb_elastic_tb_top;
    import rxeb_pkg::*;
    logic              clk, srst, rx_link_clk, rx_link_srst, rx_in_valid;
    logic [DATA_W-1:0] rx_in_data, rx_out_data;
    logic [CTRL_W-1:0] rx_in_ctrl, rx_out_ctrl;
    logic              rx_out_fault, rx_out_inserted, rx_drop_pulse, rx_delete_pulse;
    int                miscompares, checked, drops, dels, ins, faults;
    logic [WORD_W-1:0] got[$], exp[$]; // delivered and expected data words
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rx_link_clk = 1'b0;
        #3.7;
        forever #7.5 rx_link_clk = ~rx_link_clk;
    end
    rxeb_elastic dut (.rx_link_clk(rx_link_clk), .rx_link_srst(rx_link_srst),
        .rx_in_data(rx_in_data), .rx_in_ctrl(rx_in_ctrl), .rx_in_valid(rx_in_valid),
        .clk(clk), .srst(srst), .rx_out_data(rx_out_data), .rx_out_ctrl(rx_out_ctrl),
        .rx_out_fault(rx_out_fault), .rx_out_inserted(rx_out_inserted),
        .rx_drop_pulse(rx_drop_pulse), .rx_delete_pulse(rx_delete_pulse));
    rxeb_link_src src (.rx_link_clk(rx_link_clk), .rx_link_srst(rx_link_srst),
        .rx_in_data(rx_in_data), .rx_in_ctrl(rx_in_ctrl), .rx_in_valid(rx_in_valid));
    // monitor: count events, keep plain data words
    always @(negedge clk) begin
        if (!srst) begin
            drops += int'(rx_drop_pulse);
            dels += int'(rx_delete_pulse);
            ins += int'(rx_out_inserted);
            faults += int'(rx_out_fault);
            if (rx_out_fault === 1'b0 && rx_out_inserted === 1'b0
                && {rx_out_ctrl, rx_out_data} !== {RM_CTRL, RM_DATA}) begin
                got.push_back({rx_out_ctrl, rx_out_data});
            end
        end
    end
    task automatic cmp(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] e);
        checked++;
        if (a !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic send(input int n, input logic [7:0] tag);
        logic [WORD_W-1:0] w;
        for (int i = 0; i < n; i++) begin
            w = {8'h00, tag, 56'(i)};
            src.push(w);
            exp.push_back(w);
        end
    endtask
    task automatic wait_n(input int n);
        for (int i = 0; i < 3000 && got.size() < n; i++) @(negedge clk);
    endtask
    task automatic wait_fault;
        for (int i = 0; i < 3000 && rx_out_fault !== 1'b1; i++) @(negedge clk);
        cmp(rx_out_fault, 1'b1);
    endtask
    task automatic chk_all;
        foreach (exp[i]) cmp(i < got.size() ? got[i] : 'x, exp[i]);
        got.delete();
        exp.delete();
    endtask
    task automatic t_order;
        send(20, 8'h01);
        wait_n(20);
        chk_all();
        wait_fault();
    endtask
    task automatic t_delete;
        dels = 0;
        send(16, 8'h02);
        repeat (6) src.push({RM_CTRL, RM_DATA});
        send(4, 8'h03);
        wait_n(16);
        // kept rate match word is repeated until fresh words lift the fill
        send(16, 8'h07);
        wait_n(36);
        chk_all();
        cmp(dels > 0, 1'b1);
        wait_fault();
    endtask
    task automatic t_insert;
        send(16, 8'h04);
        src.push({RM_CTRL, RM_DATA});
        wait_n(16);
        ins = 0;
        faults = 0;
        repeat (10) @(negedge clk);
        cmp(ins > 0, 1'b1);
        cmp(faults, 0);
        send(16, 8'h05);
        wait_n(32);
        chk_all();
        wait_fault();
    endtask
    task automatic t_overflow;
        drops = 0;
        send(48, 8'h06);
        wait_n(1);
        wait_fault();
        cmp(drops > 0, 1'b1);
        cmp(got[0], exp[0]);
        cmp(got.size() < 48, 1'b1);
        got.delete();
        exp.delete();
    endtask
    task automatic wrap_up;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
    // main sequence
    initial begin
        srst = 1'b1;
        rx_link_srst = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge rx_link_clk);
        rx_link_srst <= 1'b0;
        @(negedge clk);
        cmp({rx_out_ctrl, rx_out_data}, {LF_CTRL, LF_DATA});
        $display("reset done");
        t_order();
        $display("order done");
        t_delete();
        $display("delete done");
        t_insert();
        $display("insert done");
        t_overflow();
        $display("overflow done");
        wrap_up();
    end
endmodule
